//--- tmr_pkg.sv
// package of register map constants and carrier types for the thermal monitor register file
package tmr_pkg;

  localparam logic [7:0] ADDR_COMMON_STATUS = 8'h02;
  localparam logic [7:0] ADDR_CONFIGURATION = 8'h03;
  localparam logic [7:0] ADDR_CONVERSION_RATE = 8'h04;
  localparam logic [7:0] ADDR_CHANNEL_ENABLE = 8'h05;
  localparam logic [7:0] ADDR_FILTER_SETTING = 8'h06;
  localparam logic [7:0] ADDR_DIODE_FAULT = 8'h07;
  localparam logic [7:0] ADDR_THRESH1_STATUS = 8'h08;
  localparam logic [7:0] ADDR_THRESH2_STATUS = 8'h09;
  localparam logic [7:0] ADDR_THRESH3_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_THRESH1_MASK = 8'h0c;
  localparam logic [7:0] ADDR_THRESH2_MASK = 8'h0d;
  localparam logic [7:0] ADDR_THRESH3_MASK = 8'h0e;
  localparam logic [7:0] ADDR_ONE_SHOT = 8'h0f;
  localparam logic [7:0] ADDR_HIGH_BASE = 8'h10;
  localparam logic [7:0] ADDR_LOW_BASE = 8'h20;
  localparam logic [7:0] ADDR_DIODE_MODEL_SEL = 8'h30;
  localparam logic [7:0] ADDR_REMOTE1_OFFSET = 8'h31;
  localparam logic [7:0] ADDR_REMOTE4_OFFSET = 8'h34;
  localparam logic [7:0] ADDR_DIODE_MODEL_STAT = 8'h38;
  localparam logic [7:0] ADDR_LOCAL_CRIT = 8'h40;
  localparam logic [7:0] ADDR_REMOTE1_FIRST = 8'h41;
  localparam logic [7:0] ADDR_REMOTE2_FIRST = 8'h42;
  localparam logic [7:0] ADDR_REMOTE3_LIMIT = 8'h43;
  localparam logic [7:0] ADDR_REMOTE4_LIMIT = 8'h44;
  localparam logic [7:0] ADDR_REMOTE1_SECOND = 8'h49;
  localparam logic [7:0] ADDR_REMOTE2_SECOND = 8'h4a;
  localparam logic [7:0] ADDR_HYSTERESIS = 8'h5a;
  localparam logic [7:0] ADDR_MAKER_CODE = 8'hfe;
  localparam logic [7:0] ADDR_REVISION_CODE = 8'hff;

  // temperature channels: 0 local signed, 1..4 remote signed, 9..12 remote unsigned
  localparam int NUM_CHANNELS = 13;
  localparam logic [7:0] CHAN_INDEX_MASK = 8'h0f;
  localparam logic [15:0] CHAN_VALID = 16'h1e1f;

  localparam logic [7:0] RST_CONFIGURATION = 8'h03;
  localparam logic [7:0] RST_CONVERSION_RATE = 8'h02;
  localparam logic [7:0] RST_CHANNEL_ENABLE = 8'h1f;
  localparam logic [7:0] RST_FILTER_SETTING = 8'h0f;
  localparam logic [7:0] RST_THRESH1_MASK = 8'h19;
  localparam logic [7:0] RST_THRESH2_MASK = 8'h00;
  localparam logic [7:0] RST_THRESH3_MASK = 8'h07;
  localparam logic [7:0] RST_DIODE_MODEL_SEL = 8'h02;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_LOCAL_CRIT = 8'h55;
  localparam logic [7:0] RST_FIRST_LIMIT = 8'h6e;
  localparam logic [7:0] RST_SINGLE_LIMIT = 8'h55;
  localparam logic [7:0] RST_SECOND_LIMIT = 8'h55;
  localparam logic [7:0] RST_HYSTERESIS = 8'h0a;
  localparam logic [7:0] RST_POINTER = 8'h00;

  // writable bit masks, then read-back masks for the low bytes, threshold status and model status
  localparam logic [7:0] WMASK_CONFIGURATION = 8'h43;
  localparam logic [7:0] WMASK_CONVERSION_RATE = 8'h03;
  localparam logic [7:0] WMASK_CHANNEL_ENABLE = 8'h1f;
  localparam logic [7:0] WMASK_FILTER_SETTING = 8'h0f;
  localparam logic [7:0] WMASK_THRESH_MASK = 8'h1f;
  localparam logic [7:0] WMASK_DIODE_MODEL_SEL = 8'h1e;
  localparam logic [7:0] WMASK_LOCAL_CRIT = 8'h7f;
  localparam logic [7:0] WMASK_HYSTERESIS = 8'h1f;
  localparam logic [7:0] LOW_PLAIN_MASK = 8'he0;
  localparam logic [7:0] LOW_FILTER_MASK = 8'hf8;
  localparam logic [7:0] STATUS5_MASK = 8'h1f;
  localparam logic [7:0] MODEL_STAT_MASK = 8'h1e;

  localparam int CFG_STANDBY_BIT = 6;

  // arbitrary identity values
  localparam logic [7:0] MAKER_CODE_VALUE = 8'h5a;
  localparam logic [7:0] REVISION_CODE_VALUE = 8'h10;

  typedef struct packed {
    logic writeStrobe;
    logic readStrobe;
    logic commandStrobe;
    logic [7:0] data;
  } tmr_bus_req_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } tmr_temp_t;

  typedef struct packed {
    logic [7:0] diodeFault;
    logic [7:0] thresh1;
    logic [7:0] thresh2;
    logic [7:0] thresh3;
    logic [7:0] modelStatus;
    logic [7:0] common;
  } tmr_status_t;

endpackage

//--- tmr_register_file.sv
// command-byte addressed register file of the thermal monitor
`timescale 1ns/1ps
module tmr_register_file
  import tmr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire tmr_bus_req_t busReq,
  input wire tmr_temp_t tempIn [NUM_CHANNELS],
  input wire tmr_status_t statusIn,
  output logic [7:0] readData,
  output logic oneShotStart,
  output logic standbyMode,
  output logic [7:0] convRate,
  output logic [7:0] channelEnable,
  output logic [7:0] filterSetting,
  output logic [7:0] configuration,
  output logic [7:0] thresh1Mask,
  output logic [7:0] thresh2Mask,
  output logic [7:0] thresh3Mask,
  output logic [7:0] diodeModelSel,
  output logic [31:0] offsets,
  output logic [7:0] localCritLimit,
  output logic [15:0] firstLimits,
  output logic [15:0] singleLimits,
  output logic [15:0] secondLimits,
  output logic [7:0] hysteresis
);

  logic [7:0] pointer_reg;
  logic [7:0] frozenLow_reg [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] frozen_reg;
  logic [7:0] offsets_reg [4];
  logic [7:0] readData_next;
  logic [3:0] chanIdx;
  logic isHigh;
  logic isLow;
  logic chanOk;
  logic [7:0] lowMask;
  logic [7:0] liveLow;
  logic [7:0] shownLow;

  // pointer holds across transactions so a bare read reuses it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pointer_reg <= RST_POINTER;
    end else if (clockEnable && busReq.commandStrobe) begin
      pointer_reg <= busReq.data;
    end
  end

  assign chanIdx = pointer_reg[3:0];
  assign chanOk = CHAN_VALID[chanIdx];
  assign isHigh = ((pointer_reg & ~CHAN_INDEX_MASK) == ADDR_HIGH_BASE) && chanOk;
  assign isLow = ((pointer_reg & ~CHAN_INDEX_MASK) == ADDR_LOW_BASE) && chanOk;

  // filtered remote one and two keep two extra fraction bits
  always_comb begin
    lowMask = LOW_PLAIN_MASK;
    if ((chanIdx == 4'h1 || chanIdx == 4'h9) && filterSetting[1:0] != 2'b00) begin
      lowMask = LOW_FILTER_MASK;
    end
    if ((chanIdx == 4'h2 || chanIdx == 4'ha) && filterSetting[3:2] != 2'b00) begin
      lowMask = LOW_FILTER_MASK;
    end
    liveLow = 8'h00;
    shownLow = 8'h00;
    if (chanOk) begin
      liveLow = tempIn[chanIdx].low & lowMask;
      shownLow = frozen_reg[chanIdx] ? frozenLow_reg[chanIdx] : liveLow;
    end
  end

  // low-byte lock: read of high captures, read of low releases
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frozen_reg <= '0;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        frozenLow_reg[i] <= 8'h00;
      end
    end else if (clockEnable && busReq.readStrobe) begin
      if (isHigh) begin
        frozen_reg[chanIdx] <= 1'b1;
        frozenLow_reg[chanIdx] <= liveLow;
      end else if (isLow) begin
        frozen_reg[chanIdx] <= 1'b0;
      end
    end
  end

  // writable configuration and limits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      configuration <= RST_CONFIGURATION;
      convRate <= RST_CONVERSION_RATE;
      channelEnable <= RST_CHANNEL_ENABLE;
      filterSetting <= RST_FILTER_SETTING;
      thresh1Mask <= RST_THRESH1_MASK;
      thresh2Mask <= RST_THRESH2_MASK;
      thresh3Mask <= RST_THRESH3_MASK;
      diodeModelSel <= RST_DIODE_MODEL_SEL;
      localCritLimit <= RST_LOCAL_CRIT;
      firstLimits <= {RST_FIRST_LIMIT, RST_FIRST_LIMIT};
      singleLimits <= {RST_SINGLE_LIMIT, RST_SINGLE_LIMIT};
      secondLimits <= {RST_SECOND_LIMIT, RST_SECOND_LIMIT};
      hysteresis <= RST_HYSTERESIS;
      for (int i = 0; i < 4; i++) begin
        offsets_reg[i] <= RST_OFFSET;
      end
    end else if (clockEnable && busReq.writeStrobe) begin
      // read-only and unmapped locations fall through untouched
      if (pointer_reg == ADDR_CONFIGURATION) begin
        configuration <= busReq.data & WMASK_CONFIGURATION;
      end else if (pointer_reg == ADDR_CONVERSION_RATE) begin
        convRate <= busReq.data & WMASK_CONVERSION_RATE;
      end else if (pointer_reg == ADDR_CHANNEL_ENABLE) begin
        channelEnable <= busReq.data & WMASK_CHANNEL_ENABLE;
      end else if (pointer_reg == ADDR_FILTER_SETTING) begin
        filterSetting <= busReq.data & WMASK_FILTER_SETTING;
      end else if (pointer_reg == ADDR_THRESH1_MASK) begin
        thresh1Mask <= busReq.data & WMASK_THRESH_MASK;
      end else if (pointer_reg == ADDR_THRESH2_MASK) begin
        thresh2Mask <= busReq.data & WMASK_THRESH_MASK;
      end else if (pointer_reg == ADDR_THRESH3_MASK) begin
        thresh3Mask <= busReq.data & WMASK_THRESH_MASK;
      end else if (pointer_reg == ADDR_DIODE_MODEL_SEL) begin
        diodeModelSel <= busReq.data & WMASK_DIODE_MODEL_SEL;
      end else if (pointer_reg >= ADDR_REMOTE1_OFFSET && pointer_reg <= ADDR_REMOTE4_OFFSET) begin
        offsets_reg[pointer_reg[1:0] - 2'd1] <= busReq.data;
      end else if (pointer_reg == ADDR_LOCAL_CRIT) begin
        localCritLimit <= busReq.data & WMASK_LOCAL_CRIT;
      end else if (pointer_reg == ADDR_REMOTE1_FIRST) begin
        firstLimits[7:0] <= busReq.data;
      end else if (pointer_reg == ADDR_REMOTE2_FIRST) begin
        firstLimits[15:8] <= busReq.data;
      end else if (pointer_reg == ADDR_REMOTE3_LIMIT) begin
        singleLimits[7:0] <= busReq.data;
      end else if (pointer_reg == ADDR_REMOTE4_LIMIT) begin
        singleLimits[15:8] <= busReq.data;
      end else if (pointer_reg == ADDR_REMOTE1_SECOND) begin
        secondLimits[7:0] <= busReq.data;
      end else if (pointer_reg == ADDR_REMOTE2_SECOND) begin
        secondLimits[15:8] <= busReq.data;
      end else if (pointer_reg == ADDR_HYSTERESIS) begin
        hysteresis <= busReq.data & WMASK_HYSTERESIS;
      end
    end
  end

  always_comb begin
    offsets = {offsets_reg[3], offsets_reg[2], offsets_reg[1], offsets_reg[0]};
  end

  // one-shot is a pulse only; data is dropped, and a running device ignores it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oneShotStart <= 1'b0;
    end else if (clockEnable) begin
      oneShotStart <= busReq.writeStrobe && pointer_reg == ADDR_ONE_SHOT &&
        configuration[CFG_STANDBY_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      standbyMode <= 1'b0;
    end else if (clockEnable) begin
      standbyMode <= configuration[CFG_STANDBY_BIT];
    end
  end

  // read mux; unmapped and the one-shot location return zero
  always_comb begin
    readData_next = 8'h00;
    if (isHigh) begin
      readData_next = tempIn[chanIdx].high;
    end else if (isLow) begin
      readData_next = shownLow;
    end else if (pointer_reg == ADDR_COMMON_STATUS) begin
      readData_next = statusIn.common;
    end else if (pointer_reg == ADDR_CONFIGURATION) begin
      readData_next = configuration;
    end else if (pointer_reg == ADDR_CONVERSION_RATE) begin
      readData_next = convRate;
    end else if (pointer_reg == ADDR_CHANNEL_ENABLE) begin
      readData_next = channelEnable;
    end else if (pointer_reg == ADDR_FILTER_SETTING) begin
      readData_next = filterSetting;
    end else if (pointer_reg == ADDR_DIODE_FAULT) begin
      readData_next = statusIn.diodeFault;
    end else if (pointer_reg == ADDR_THRESH1_STATUS) begin
      readData_next = statusIn.thresh1 & STATUS5_MASK;
    end else if (pointer_reg == ADDR_THRESH2_STATUS) begin
      readData_next = statusIn.thresh2 & STATUS5_MASK;
    end else if (pointer_reg == ADDR_THRESH3_STATUS) begin
      readData_next = statusIn.thresh3 & STATUS5_MASK;
    end else if (pointer_reg == ADDR_THRESH1_MASK) begin
      readData_next = thresh1Mask;
    end else if (pointer_reg == ADDR_THRESH2_MASK) begin
      readData_next = thresh2Mask;
    end else if (pointer_reg == ADDR_THRESH3_MASK) begin
      readData_next = thresh3Mask;
    end else if (pointer_reg == ADDR_ONE_SHOT) begin
      readData_next = 8'h00;
    end else if (pointer_reg == ADDR_DIODE_MODEL_SEL) begin
      readData_next = diodeModelSel;
    end else if (pointer_reg >= ADDR_REMOTE1_OFFSET && pointer_reg <= ADDR_REMOTE4_OFFSET) begin
      readData_next = offsets_reg[pointer_reg[1:0] - 2'd1];
    end else if (pointer_reg == ADDR_DIODE_MODEL_STAT) begin
      readData_next = statusIn.modelStatus & MODEL_STAT_MASK;
    end else if (pointer_reg == ADDR_LOCAL_CRIT) begin
      readData_next = localCritLimit;
    end else if (pointer_reg == ADDR_REMOTE1_FIRST) begin
      readData_next = firstLimits[7:0];
    end else if (pointer_reg == ADDR_REMOTE2_FIRST) begin
      readData_next = firstLimits[15:8];
    end else if (pointer_reg == ADDR_REMOTE3_LIMIT) begin
      readData_next = singleLimits[7:0];
    end else if (pointer_reg == ADDR_REMOTE4_LIMIT) begin
      readData_next = singleLimits[15:8];
    end else if (pointer_reg == ADDR_REMOTE1_SECOND) begin
      readData_next = secondLimits[7:0];
    end else if (pointer_reg == ADDR_REMOTE2_SECOND) begin
      readData_next = secondLimits[15:8];
    end else if (pointer_reg == ADDR_HYSTERESIS) begin
      readData_next = hysteresis;
    end else if (pointer_reg == ADDR_MAKER_CODE) begin
      readData_next = MAKER_CODE_VALUE;
    end else if (pointer_reg == ADDR_REVISION_CODE) begin
      readData_next = REVISION_CODE_VALUE;
    end
  end

  // registered so the serial engine can shift it out without glitches
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readData <= 8'h00;
    end else if (clockEnable) begin
      readData <= readData_next;
    end
  end

  a_high_freezes_low: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.readStrobe && isHigh |=> frozen_reg[$past(chanIdx)])
    else $error("high read did not freeze low byte");

  a_low_read_releases: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.readStrobe && isLow |=> !frozen_reg[$past(chanIdx)])
    else $error("low read did not release lock");

  a_recapture_on_high: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.readStrobe && isHigh |=>
      frozenLow_reg[$past(chanIdx)] == $past(liveLow))
    else $error("high read did not recapture low byte");

  a_low_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && isLow && chanIdx == 4'h0 |=> readData[4:0] == 5'h00)
    else $error("local low reserved bits not zero");

  a_crit_bit7_zero: assert property (@(posedge clock) disable iff (!rst_n)
    localCritLimit[7] == 1'b0)
    else $error("local critical limit bit 7 set");

  a_pointer_holds: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.commandStrobe |=> pointer_reg == $past(busReq.data))
    else $error("command byte not latched");

  a_oneshot_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && pointer_reg == ADDR_ONE_SHOT |=> readData == 8'h00)
    else $error("one-shot location read nonzero");

  a_oneshot_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.writeStrobe && pointer_reg == ADDR_ONE_SHOT &&
      configuration[CFG_STANDBY_BIT] |=>
      oneShotStart ##1 (!oneShotStart || $past(busReq.writeStrobe)))
    else $error("one-shot start not pulsed");

  a_readonly_write: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.writeStrobe && pointer_reg == ADDR_DIODE_FAULT |=>
      $stable(configuration) && $stable(localCritLimit) && $stable(firstLimits))
    else $error("read-only write changed a register");

  a_local_high_value: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && isHigh && chanIdx == 4'h0 |=> readData == $past(tempIn[0].high))
    else $error("local high byte not shown");

  a_local_low_live: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && isLow && chanIdx == 4'h0 && !frozen_reg[0] |=>
      readData[7:5] == $past(tempIn[0].low[7:5]))
    else $error("local fraction bits not shown");

  a_frozen_low_shown: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && isLow && frozen_reg[chanIdx] |=> readData == $past(frozenLow_reg[chanIdx]))
    else $error("frozen low byte not shown");

  a_lock_holds: assert property (@(posedge clock) disable iff (!rst_n)
    !(clockEnable && busReq.readStrobe) |=> $stable(frozen_reg))
    else $error("lock changed without a read");

  a_unsigned_low_zero: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && isLow && chanIdx == 4'hc |=> readData[4:0] == 5'h00)
    else $error("unsigned low reserved bits not zero");

  a_crit_write: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.writeStrobe && pointer_reg == ADDR_LOCAL_CRIT |=>
      localCritLimit == ($past(busReq.data) & WMASK_LOCAL_CRIT))
    else $error("local critical limit not written");

  a_first_limit_one: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.writeStrobe && pointer_reg == ADDR_REMOTE1_FIRST |=>
      firstLimits[7:0] == $past(busReq.data))
    else $error("remote one first limit not written");

  a_first_limit_two: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.writeStrobe && pointer_reg == ADDR_REMOTE2_FIRST |=>
      firstLimits[15:8] == $past(busReq.data))
    else $error("remote two first limit not written");

  a_second_limit_one: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.writeStrobe && pointer_reg == ADDR_REMOTE1_SECOND |=>
      secondLimits[7:0] == $past(busReq.data))
    else $error("remote one second limit not written");

  a_second_limit_two: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.writeStrobe && pointer_reg == ADDR_REMOTE2_SECOND |=>
      secondLimits[15:8] == $past(busReq.data))
    else $error("remote two second limit not written");

  a_single_limit_three: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.writeStrobe && pointer_reg == ADDR_REMOTE3_LIMIT |=>
      singleLimits[7:0] == $past(busReq.data))
    else $error("remote three limit not written");

  a_single_limit_four: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && busReq.writeStrobe && pointer_reg == ADDR_REMOTE4_LIMIT |=>
      singleLimits[15:8] == $past(busReq.data))
    else $error("remote four limit not written");

  a_fault_flags_read: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && pointer_reg == ADDR_DIODE_FAULT |=>
      readData == $past(statusIn.diodeFault))
    else $error("diode fault flags not shown");

  a_pointer_stable: assert property (@(posedge clock) disable iff (!rst_n)
    !(clockEnable && busReq.commandStrobe) |=> $stable(pointer_reg))
    else $error("pointer moved without a command");

  a_oneshot_idle: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && !(busReq.writeStrobe && pointer_reg == ADDR_ONE_SHOT) |=>
      !oneShotStart)
    else $error("one-shot start without a trigger write");

  a_oneshot_running: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && !configuration[CFG_STANDBY_BIT] |=> !oneShotStart)
    else $error("one-shot start outside standby");

endmodule

//--- tmr_host_model.sv
// behavioural serial-bus host that drives the register file request strobes
`timescale 1ns/1ps
module tmr_host_model
  import tmr_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] readData,
  output tmr_bus_req_t busReq
);
  initial begin
    busReq = '0;
  end

  // command byte: one-cycle pulse that becomes the pointer
  task automatic cmd(input logic [7:0] a);
    @(posedge clock);
    busReq.commandStrobe <= 1'b1;
    busReq.data <= a;
    @(posedge clock);
    busReq.commandStrobe <= 1'b0;
    busReq.data <= ~a;
  endtask

  // data byte to the pointed register; data is scrambled once released
  task automatic wr(input logic [7:0] d);
    @(posedge clock);
    busReq.writeStrobe <= 1'b1;
    busReq.data <= d;
    @(posedge clock);
    busReq.writeStrobe <= 1'b0;
    busReq.data <= ~d;
  endtask

  // waits out the registered read path, then marks the byte consumed
  task automatic rd(output logic [7:0] d);
    repeat (3) @(posedge clock);
    d = readData;
    busReq.readStrobe <= 1'b1;
    @(posedge clock);
    busReq.readStrobe <= 1'b0;
  endtask

  // high byte first so both halves come from one conversion
  task automatic rdPair(input logic [7:0] ch, output logic [7:0] hi, output logic [7:0] lo);
    cmd(ADDR_HIGH_BASE + ch);
    rd(hi);
    cmd(ADDR_LOW_BASE + ch);
    rd(lo);
  endtask
endmodule

//--- tb.sv
// self-checking testbench of the thermal monitor register file
`timescale 1ns/1ps
module tb;
  import tmr_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] rstVal;
    logic [7:0] fullVal;
  } tmr_row_t;

  logic clock;
  logic rst_n;
  logic clockEnable;
  tmr_bus_req_t busReq;
  tmr_temp_t temps [NUM_CHANNELS];
  tmr_status_t statusIn = {8'h96, 8'hff, 8'he2, 8'h3c, 8'hff, 8'hc5};
  logic [7:0] readData;
  logic oneShotStart;
  logic standbyMode;
  logic [7:0] localCritLimit;
  logic [15:0] firstLimits;
  logic [15:0] singleLimits;
  logic [15:0] secondLimits;
  logic [7:0] convRate, channelEnable, filterSetting, configuration, diodeModelSel;
  logic [7:0] thresh1Mask, thresh2Mask, thresh3Mask, hysteresis;
  logic [31:0] offsets;
  logic [7:0] v;
  logic [7:0] hi;
  logic [7:0] lo;
  int badCount = 0;
  int cmpCount = 0;
  int pulses = 0;
  int p;

  // address, reset value, value read back after writing all ones
  tmr_row_t rows [29] = '{
    '{8'h03, 8'h03, 8'h43}, '{8'h04, 8'h02, 8'h03}, '{8'h05, 8'h1f, 8'h1f},
    '{8'h06, 8'h0f, 8'h0f}, '{8'h0c, 8'h19, 8'h1f}, '{8'h0d, 8'h00, 8'h1f},
    '{8'h0e, 8'h07, 8'h1f}, '{8'h30, 8'h02, 8'h1e}, '{8'h31, 8'h00, 8'hff},
    '{8'h34, 8'h00, 8'hff}, '{8'h40, 8'h55, 8'h7f}, '{8'h41, 8'h6e, 8'hff},
    '{8'h42, 8'h6e, 8'hff}, '{8'h43, 8'h55, 8'hff}, '{8'h44, 8'h55, 8'hff},
    '{8'h49, 8'h55, 8'hff}, '{8'h4a, 8'h55, 8'hff}, '{8'h5a, 8'h0a, 8'h1f},
    '{8'h0f, 8'h00, 8'h00}, '{8'h01, 8'h00, 8'h00}, '{8'h32, 8'h00, 8'hff},
    '{8'h33, 8'h00, 8'hff}, '{8'h02, 8'hc5, 8'hc5}, '{8'h08, 8'h1f, 8'h1f},
    '{8'h09, 8'h02, 8'h02}, '{8'h0a, 8'h1c, 8'h1c}, '{8'h38, 8'h1e, 8'h1e},
    '{8'hfe, MAKER_CODE_VALUE, MAKER_CODE_VALUE},
    '{8'hff, REVISION_CODE_VALUE, REVISION_CODE_VALUE}
  };

  tmr_register_file i_dut (
    .clock(clock), .rst_n(rst_n), .clockEnable(clockEnable), .busReq(busReq),
    .tempIn(temps), .statusIn(statusIn), .readData(readData),
    .oneShotStart(oneShotStart), .standbyMode(standbyMode), .convRate(convRate),
    .channelEnable(channelEnable), .filterSetting(filterSetting),
    .configuration(configuration), .thresh1Mask(thresh1Mask),
    .thresh2Mask(thresh2Mask), .thresh3Mask(thresh3Mask),
    .diodeModelSel(diodeModelSel), .offsets(offsets),
    .localCritLimit(localCritLimit), .firstLimits(firstLimits),
    .singleLimits(singleLimits), .secondLimits(secondLimits), .hysteresis(hysteresis)
  );

  tmr_host_model i_host (
    .clock(clock), .readData(readData), .busReq(busReq)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // one-shot pulses are single cycles, so counting edges counts starts
  always @(posedge clock) begin
    if (oneShotStart === 1'b1) begin
      pulses++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic setTemp(input int ch, input logic [7:0] h, input logic [7:0] l);
    @(posedge clock);
    temps[ch] <= {h, l};
    repeat (2) @(posedge clock);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    badCount++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    clockEnable = 1'b1;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      temps[i] = '0;
    end
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      i_host.cmd(rows[i].addr);
      i_host.rd(v);
      check(v, rows[i].rstVal);
      i_host.wr(8'hff);
      i_host.rd(v);
      check(v, rows[i].fullVal);
    end
    check(localCritLimit, 8'h7f);
    check(firstLimits, 16'hffff);
    check(secondLimits, 16'hffff);
    check(singleLimits, 16'hffff);
    check(configuration, 8'h43);
    check(convRate, 8'h03);
    check(channelEnable, 8'h1f);
    check(filterSetting, 8'h0f);
    check({thresh1Mask, thresh2Mask}, 16'h1f1f);
    check(thresh3Mask, 8'h1f);
    check(diodeModelSel, 8'h1e);
    check(hysteresis, 8'h1f);
    check(offsets[31:16], 16'hffff);
    check(offsets[15:0], 16'hffff);
    $display("test register table done");

    // a second reset in mid-run must bring the defaults back
    @(posedge clock) rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    check(readData, 8'h00);
    check(localCritLimit, 8'h55);
    check(firstLimits, 16'h6e6e);
    check(secondLimits, 16'h5555);
    check(singleLimits, 16'h5555);
    check(configuration, 8'h03);
    check(offsets[15:0], 16'h0000);
    @(posedge clock) rst_n <= 1'b1;
    $display("test mid-run reset done");

    // the trigger only fires in standby and never stores its data
    p = pulses;
    i_host.cmd(ADDR_ONE_SHOT);
    i_host.wr(8'h5a);
    repeat (3) @(posedge clock);
    check(16'(pulses - p), 16'h0000);
    i_host.cmd(ADDR_CONFIGURATION);
    i_host.wr(8'h43);
    i_host.cmd(ADDR_ONE_SHOT);
    i_host.wr(8'h00);
    repeat (3) @(posedge clock);
    check(16'(pulses - p), 16'h0001);
    check(standbyMode, 1'b1);
    i_host.rd(v);
    check(v, 8'h00);
    $display("test one-shot done");

    // a write while the enable is low is not taken
    i_host.cmd(ADDR_LOCAL_CRIT);
    @(posedge clock) clockEnable <= 1'b0;
    i_host.wr(8'h12);
    @(posedge clock) clockEnable <= 1'b1;
    i_host.rd(v);
    check(v, 8'h55);
    $display("test clock enable done");

    // repeated high reads recapture; the low read releases the lock
    setTemp(0, 8'h80, 8'ha0);
    i_host.cmd(ADDR_HIGH_BASE);
    i_host.rd(v);
    check(v, 8'h80);
    setTemp(0, 8'h7f, 8'hc0);
    i_host.rd(v);
    check(v, 8'h7f);
    setTemp(0, 8'h7f, 8'he0);
    i_host.cmd(ADDR_LOW_BASE);
    i_host.rd(v);
    check(v, 8'hc0);
    setTemp(0, 8'h7f, 8'hff);
    i_host.rd(v);
    check(v, 8'he0);
    $display("test low byte lock done");

    setTemp(12, 8'hc8, 8'hff);
    i_host.rdPair(8'h0c, hi, lo);
    check(hi, 8'hc8);
    check(lo, 8'he0);
    i_host.wr(8'h00);
    i_host.rd(v);
    check(v, 8'he0);
    $display("test unsigned low byte done");

    // filtered remote one keeps two extra fraction bits until the filter is off
    setTemp(1, 8'h19, 8'hff);
    i_host.rdPair(8'h01, hi, lo);
    check(hi, 8'h19);
    check(lo, 8'hf8);
    i_host.cmd(ADDR_FILTER_SETTING);
    i_host.wr(8'h00);
    i_host.cmd(ADDR_LOW_BASE + 8'h01);
    i_host.rd(v);
    check(v, 8'he0);
    $display("test filtered low byte done");

    i_host.cmd(ADDR_DIODE_FAULT);
    i_host.rd(v);
    check(v, 8'h96);
    i_host.wr(8'h00);
    i_host.rd(v);
    check(v, 8'h96);
    @(posedge clock) statusIn <= {8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    i_host.rd(v);
    check(v, 8'h41);
    i_host.cmd(ADDR_MAKER_CODE);
    i_host.wr(8'h00);
    i_host.rd(v);
    check(v, MAKER_CODE_VALUE);
    $display("test read-only places done");
    conclude();
  end
endmodule
